// file: rtl/lxl_exit_latency.sv
// link power-state exit latency fields with override tracking
`include "lxl_cfg.svh"
`default_nettype none
module lxl_exit_latency
	import lxl_pkg::*;
(
	input  wire logic                   CORE_CLK,
	input  wire logic                   NRST,
	input  wire logic                   SHARED_REFCLK_BIT,
	input  wire lxl_wr_s                SW_WR,
	input  wire lxl_wr_s                EE_WR,
	output logic [`LXL_REG_W-1:0]       REG_RDATA,
	output var lxl_cap_s                LINK_CAP,
	output logic                        STBY_OVERRIDE,
	output logic                        DEEP_OVERRIDE
);
	// override flags, one per field, kept until reset
	logic      stby_flag;
	logic      deep_flag;

	// presented field values, held in flip-flops
	lxl_code_t stby_field;
	lxl_code_t deep_field;

	// merged write strobes from software and the eeprom loader
	logic      stby_we;
	logic      deep_we;

	// merged write data, software first
	lxl_code_t stby_wd;
	lxl_code_t deep_wd;

	// a write that would change the presented value
	logic      stby_take;
	logic      deep_take;

	// next values of the registered state
	logic      next_stby_flag;
	logic      next_deep_flag;
	lxl_code_t next_stby_field;
	lxl_code_t next_deep_field;

	// standby default code for a given common-clock level
	function automatic lxl_code_t stby_default(input logic shared_clk);
		lxl_code_t code;
		if (shared_clk) begin
			code = `LXL_STBY_DEF_CC;
		end else begin
			code = `LXL_STBY_DEF_NCC;
		end
		return code;
	endfunction

	// data of a write: software wins over a same-cycle eeprom load
	function automatic lxl_code_t pick_data(
		input logic      sw_we,
		input lxl_code_t sw_data,
		input lxl_code_t ee_data
	);
		lxl_code_t code;
		if (sw_we) begin
			code = sw_data;
		end else begin
			code = ee_data;
		end
		return code;
	endfunction

	// a write only counts when it differs from what is presented
	function automatic logic differs(
		input logic      we,
		input lxl_code_t wd,
		input lxl_code_t cur
	);
		logic hit;
		hit = we && (wd != cur);
		return hit;
	endfunction

	// standby write merge
	assign stby_we   = SW_WR.stby_we | EE_WR.stby_we;
	assign stby_wd   = pick_data(SW_WR.stby_we, SW_WR.stby_data, EE_WR.stby_data);
	assign stby_take = differs(stby_we, stby_wd, stby_field);

	// deep idle write merge
	assign deep_we   = SW_WR.deep_we | EE_WR.deep_we;
	assign deep_wd   = pick_data(SW_WR.deep_we, SW_WR.deep_data, EE_WR.deep_data);
	assign deep_take = differs(deep_we, deep_wd, deep_field);

	// standby next state: written value, else default while not overridden
	always_comb begin
		next_stby_flag  = stby_flag;
		next_stby_field = stby_field;
		if (stby_take) begin
			next_stby_flag  = 1'b1;
			next_stby_field = stby_wd;
		end else if (!stby_flag) begin
			next_stby_field = stby_default(SHARED_REFCLK_BIT);
		end
	end

	// deep idle next state: written value, else hold
	always_comb begin
		next_deep_flag  = deep_flag;
		next_deep_field = deep_field;
		if (deep_take) begin
			next_deep_flag  = 1'b1;
			next_deep_field = deep_wd;
		end
	end

	// standby override flag, cleared only by the fundamental reset
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			stby_flag <= 1'b0;
		end else begin
			stby_flag <= next_stby_flag;
		end
	end

	// standby field; reset loads the non-common-clock default, shown until the first clock after reset
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			stby_field <= `LXL_STBY_DEF_NCC;
		end else begin
			stby_field <= next_stby_field;
		end
	end

	// deep idle override flag
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			deep_flag <= 1'b0;
		end else begin
			deep_flag <= next_deep_flag;
		end
	end

	// deep idle field
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			deep_field <= `LXL_DEEP_DEF;
		end else begin
			deep_field <= next_deep_field;
		end
	end

	// register image, capability fields and flags, all from flops
	assign REG_RDATA     = {stby_field, deep_field};
	assign LINK_CAP      = '{stby_exit: stby_field, deep_exit: deep_field};
	assign STBY_OVERRIDE = stby_flag;
	assign DEEP_OVERRIDE = deep_flag;

	// standby default follows the common-clock level one cycle later
	stby_default_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && !STBY_OVERRIDE && !stby_we
		|=> LINK_CAP.stby_exit == stby_default($past(SHARED_REFCLK_BIT)))
		else $error("standby default wrong");

	// override flag never drops while out of reset
	stby_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		STBY_OVERRIDE |=> STBY_OVERRIDE)
		else $error("standby flag dropped");

	// differing software write is taken
	stby_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && SW_WR.stby_we && SW_WR.stby_data != LINK_CAP.stby_exit
		|=> STBY_OVERRIDE && LINK_CAP.stby_exit == $past(SW_WR.stby_data))
		else $error("standby write not taken");

	// differing eeprom load is taken
	stby_load_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && EE_WR.stby_we && !SW_WR.stby_we && EE_WR.stby_data != LINK_CAP.stby_exit
		|=> STBY_OVERRIDE && LINK_CAP.stby_exit == $past(EE_WR.stby_data))
		else $error("standby load not taken");

	// overridden value ignores the common-clock level
	stby_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && STBY_OVERRIDE && !stby_we |=> $stable(LINK_CAP.stby_exit))
		else $error("standby value moved");

	// a write equal to the presented value leaves the flag clear
	stby_refuse_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && !STBY_OVERRIDE && stby_we && stby_wd == LINK_CAP.stby_exit |=> !STBY_OVERRIDE)
		else $error("equal write set flag");

	// no write, no flag
	stby_nochg_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && !STBY_OVERRIDE && !stby_we |=> !STBY_OVERRIDE)
		else $error("flag set spuriously");

	// deep idle default while not overridden
	deep_default_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!DEEP_OVERRIDE |-> LINK_CAP.deep_exit == `LXL_DEEP_DEF)
		else $error("deep default wrong");

	// deep idle flag never drops while out of reset
	deep_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		DEEP_OVERRIDE |=> DEEP_OVERRIDE)
		else $error("deep flag dropped");

	// differing eeprom load of the deep idle field is taken
	deep_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && EE_WR.deep_we && !SW_WR.deep_we && EE_WR.deep_data != LINK_CAP.deep_exit
		|=> DEEP_OVERRIDE && LINK_CAP.deep_exit == $past(EE_WR.deep_data))
		else $error("deep load not taken");

	// differing software write of the deep idle field is taken
	deep_sw_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && SW_WR.deep_we && SW_WR.deep_data != LINK_CAP.deep_exit
		|=> DEEP_OVERRIDE && LINK_CAP.deep_exit == $past(SW_WR.deep_data))
		else $error("deep write not taken");

	// deep idle value holds without writes
	deep_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		NRST && !deep_we |=> $stable(LINK_CAP.deep_exit))
		else $error("deep value moved");

	// register image carries both fields in place
	reg_image_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		REG_RDATA[`LXL_STBY_MSB:`LXL_STBY_LSB] == LINK_CAP.stby_exit
		&& REG_RDATA[`LXL_DEEP_MSB:`LXL_DEEP_LSB] == LINK_CAP.deep_exit)
		else $error("register image mismatch");
endmodule
`default_nettype wire

// file: rtl/lxl_cfg.svh
// constants for the link exit latency configuration block
`ifndef LXL_CFG_SVH
`define LXL_CFG_SVH
`define LXL_FIELD_W       3
`define LXL_DEEP_LSB      0
`define LXL_DEEP_MSB      2
`define LXL_STBY_LSB      3
`define LXL_STBY_MSB      5
`define LXL_STBY_DEF_CC   3'h3
`define LXL_STBY_DEF_NCC  3'h4
`define LXL_DEEP_DEF      3'h4
`define LXL_REG_W         6
`endif

// file: rtl/lxl_pkg.sv
// types for the link exit latency configuration block
`include "lxl_cfg.svh"
`default_nettype none
package lxl_pkg;
	typedef logic [`LXL_FIELD_W-1:0] lxl_code_t;
	// standby and deep idle field writes from software or the eeprom loader
	typedef struct packed {
		logic      stby_we;
		lxl_code_t stby_data;
		logic      deep_we;
		lxl_code_t deep_data;
	} lxl_wr_s;
	// advertised link capability latencies
	typedef struct packed {
		lxl_code_t stby_exit;
		lxl_code_t deep_exit;
	} lxl_cap_s;
endpackage
`default_nettype wire

// file: test/lxl_ee_model.sv
// eeprom loader model driving field writes
`default_nettype none
module lxl_ee_model
	import lxl_pkg::*;
(
	input  wire logic       go_s,
	input  wire logic       go_d,
	input  wire logic [2:0] data,
	output var lxl_wr_s     ee_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	// one-cycle loader write per field, settings chosen by the bench
	assign ee_wr = '{stby_we: go_s, stby_data: data, deep_we: go_d, deep_data: data};
endmodule
`default_nettype wire

// file: test/lxl_exit_latency_tb.sv
// random bench for the exit latency fields
`include "lxl_cfg.svh"
`default_nettype none
module lxl_exit_latency_tb import lxl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ccc = 1'b0;
	logic        ee_s = 1'b0;
	logic        ee_d = 1'b0;
	logic [2:0]  ee_v = 3'h0;
	logic        fs;
	logic        fd;
	logic [5:0]  rd;
	lxl_wr_s     sw = '0;
	lxl_wr_s     ee;
	lxl_cap_s    cap;
	logic        sf = 1'b0;              // expected override flags
	logic        df = 1'b0;
	logic [2:0]  es = `LXL_STBY_DEF_NCC; // expected presented fields
	logic [2:0]  ed = `LXL_DEEP_DEF;
	logic [31:0] r;
	int          seed = 32'h2bea5ffa;
	int          n_fail = 0;
	int          check_count = 0;
	int          i;
	// 200 MHz clock
	initial forever #2.5 clk = ~clk;
	lxl_exit_latency lxl_exit_latency_inst (.CORE_CLK(clk), .NRST(nrst), .SHARED_REFCLK_BIT(ccc), .SW_WR(sw),
		.EE_WR(ee), .REG_RDATA(rd), .LINK_CAP(cap), .STBY_OVERRIDE(fs), .DEEP_OVERRIDE(fd));
	lxl_ee_model lxl_ee_model_inst (.go_s(ee_s), .go_d(ee_d), .data(ee_v), .ee_wr(ee));
	// standby default for a given common-clock level
	function automatic logic [2:0] ps(input logic c);
		return c ? `LXL_STBY_DEF_CC : `LXL_STBY_DEF_NCC;
	endfunction
	// one line per mismatch
	task automatic note(input logic ok, input string what);
		check_count++;
		if (!ok) begin
			n_fail++;
			$display("ERROR %0t: %s", $time, what);
		end
	endtask
	task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
		note(got === exp, "override flags");
	endtask
	task automatic cmp_reg(input logic [5:0] got, input logic [5:0] exp);
		note(got === exp, "register image");
	endtask
	task automatic cmp_cap(input lxl_cap_s got, input logic [5:0] exp);
		note(got === exp, "link capability");
	endtask
	// expected state after one clock edge with the inputs now applied
	task automatic step();
		logic [2:0] wd;
		wd = sw.stby_we ? sw.stby_data : ee_v;
		if ((sw.stby_we || ee_s) && wd != es) begin
			sf = 1'b1;
			es = wd;
		end else if (!sf) es = ps(ccc);
		wd = sw.deep_we ? sw.deep_data : ee_v;
		if ((sw.deep_we || ee_d) && wd != ed) begin
			df = 1'b1;
			ed = wd;
		end
	endtask
	task automatic clear_model();
		sf = 1'b0;
		df = 1'b0;
		es = `LXL_STBY_DEF_NCC;
		ed = `LXL_DEEP_DEF;
	endtask
	task automatic summarize();
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// random writes with a mid-run reset
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			if (nrst) step();
			else clear_model();
			r = $random(seed);
			if (i < 4) r = (i == 3) ? 32'h0000E031 : 32'h00002000;
			sw <= '{r[0] & r[14] & r[15], r[6:4], r[1] & r[16], r[9:7]};
			ee_s <= r[2] & r[17] & r[18];
			ee_d <= r[3] & r[19];
			ee_v <= r[12:10];
			ccc <= r[13];
			nrst <= !(i inside {[200:202]});
			@(negedge clk);
			if (!nrst) clear_model();
			cmp_flag({fs, fd}, {sf, df});
			cmp_reg(rd, {es, ed});
			cmp_cap(cap, {es, ed});
		end
		summarize();
	end
endmodule
`default_nettype wire
